//--- logic/cs_decode.sv
`timescale 1ns/10ps
`default_nettype none
module cs_decode (
  region_cfg_if.dst cfg,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] addr,
  output logic hit_first,
  output logic hit_second
);
  import ext_bus_pkg::*;

  // ==========================================================================
  // window match
  // ==========================================================================
  logic [3:0] nib;
  logic ram_hit;
  logic periph_hit;
  logic swap_cfg;

  assign nib = addr[WIN_MSB:WIN_LSB];

  always_comb begin
    ram_hit = 1'b0;
    periph_hit = 1'b0;
    unique case (cfg.ram_region_select)
      REGION_LOW: ram_hit = (nib == RAM_WIN_LOW);
      REGION_HIGH: ram_hit = (nib == RAM_WIN_HIGH);
      default: ram_hit = 1'b0;
    endcase
    unique case (cfg.peripheral_region_select)
      REGION_LOW: periph_hit = (nib == PERIPH_WIN_LOW);
      REGION_HIGH: periph_hit = (nib == PERIPH_WIN_HIGH);
      default: periph_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // chip select routing
  // ==========================================================================
  assign swap_cfg = cfg.dual_cs_mode
      && (cfg.ram_region_select != REGION_NONE)
      && (cfg.peripheral_region_select != REGION_NONE)
      && (cfg.code_region_select == REGION_NONE);

  always_comb begin
    if (swap_cfg) begin
      hit_first = ram_hit;
      hit_second = periph_hit;
    end else if (cfg.dual_cs_mode) begin
      hit_first = periph_hit;
      hit_second = ram_hit;
    end else begin
      hit_first = ram_hit | periph_hit;
      hit_second = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- logic/ext_bus_chip_select_ale.sv
// Summary of operation
// - a configuration input selects the address latch strobe polarity.
// - after reset the polarity bit is 1, strobe active high.
// - polarity bit 0 drives the address latch strobe active low.
// - swapped mapping needs dual mode, ram and peripheral nonzero, code zero.
// - in the swapped mapping, first chip select asserts for the ram window, 0x6 or 0x8.
// - in the swapped mapping, second chip select asserts for the peripheral window, 0xa or 0xc.
`timescale 1ns/10ps
`default_nettype none
module ext_bus_chip_select_ale (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_write,
  input wire logic latch_strobe_polarity_high_in,
  input wire logic [ext_bus_pkg::REGION_W-1:0] ram_region_in,
  input wire logic [ext_bus_pkg::REGION_W-1:0] peripheral_region_in,
  input wire logic [ext_bus_pkg::REGION_W-1:0] code_region_in,
  input wire logic dual_cs_mode_in,
  input wire logic req_valid,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr,
  output logic req_ready,
  output logic latch_strobe_polarity_high,
  output logic address_latch_strobe,
  output logic chip_select_first,
  output logic chip_select_second,
  output logic [ext_bus_pkg::ADDR_W-1:0] bus_addr
);
  import ext_bus_pkg::*;

  // ==========================================================================
  // configuration registers
  // ==========================================================================
  region_cfg_if cfg ();
  logic [REGION_W-1:0] ram_q;
  logic [REGION_W-1:0] periph_q;
  logic [REGION_W-1:0] code_q;
  logic dual_q;
  logic pol_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_q <= POLARITY_RESET;
      ram_q <= REGION_RESET;
      periph_q <= REGION_RESET;
      code_q <= REGION_RESET;
      dual_q <= 1'b0;
    end else if (cfg_write) begin
      pol_q <= latch_strobe_polarity_high_in;
      ram_q <= ram_region_in;
      periph_q <= peripheral_region_in;
      code_q <= code_region_in;
      dual_q <= dual_cs_mode_in;
    end
  end

  assign cfg.ram_region_select = ram_q;
  assign cfg.peripheral_region_select = periph_q;
  assign cfg.code_region_select = code_q;
  assign cfg.dual_cs_mode = dual_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_strobe_polarity_high <= POLARITY_RESET;
    end else begin
      latch_strobe_polarity_high <= pol_q;
    end
  end

  // ==========================================================================
  // decoder
  // ==========================================================================
  logic hit_first;
  logic hit_second;
  logic [ADDR_W-1:0] addr_q;

  cs_decode u_dec (
    .cfg(cfg.dst),
    .addr(addr_q),
    .hit_first(hit_first),
    .hit_second(hit_second)
  );

  // ==========================================================================
  // access sequencer: idle, address phase (strobe), data phase (selects)
  // ==========================================================================
  access_state_e st_q;
  access_state_e st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (req_valid) begin
          st_d = ST_ADDR;
        end
      end
      ST_ADDR: st_d = ST_DATA;
      ST_DATA: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else if (st_q == ST_IDLE && req_valid) begin
      addr_q <= req_addr;
    end
  end

  // ==========================================================================
  // pin outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      address_latch_strobe <= ~POLARITY_RESET;
      chip_select_first <= 1'b0;
      chip_select_second <= 1'b0;
      bus_addr <= '0;
      req_ready <= 1'b0;
    end else begin
      // strobe active at pol level, idle at its inverse
      address_latch_strobe <= (st_d == ST_ADDR) ? pol_q : ~pol_q;
      chip_select_first <= (st_d == ST_DATA) && hit_first;
      chip_select_second <= (st_d == ST_DATA) && hit_second;
      bus_addr <= (st_q == ST_IDLE && req_valid) ? req_addr : bus_addr;
      req_ready <= (st_d == ST_IDLE);
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_strobe_low_when_cleared;
    @(posedge clk) disable iff (!rst_n)
      (st_q == ST_ADDR && !pol_q) |-> !address_latch_strobe;
  endproperty
  a_strobe_low_when_cleared: assert property (p_strobe_low_when_cleared)
    else $error("strobe not active low with polarity cleared");

  property p_strobe_high_when_set;
    @(posedge clk) disable iff (!rst_n)
      (st_q == ST_ADDR && pol_q) |-> address_latch_strobe;
  endproperty
  a_strobe_high_when_set: assert property (p_strobe_high_when_set)
    else $error("strobe not active high with polarity set");

  property p_reset_polarity;
    @(posedge clk) $rose(rst_n) |-> pol_q;
  endproperty
  a_reset_polarity: assert property (p_reset_polarity)
    else $error("polarity bit not 1 after reset");

  property p_ram_to_first;
    @(posedge clk) disable iff (!rst_n)
      (st_q == ST_DATA && dual_q && ram_q != REGION_NONE
       && periph_q != REGION_NONE && code_q == REGION_NONE
       && ((ram_q == REGION_LOW && addr_q[31:28] == RAM_WIN_LOW)
        || (ram_q == REGION_HIGH && addr_q[31:28] == RAM_WIN_HIGH)))
      |-> chip_select_first && !chip_select_second;
  endproperty
  a_ram_to_first: assert property (p_ram_to_first)
    else $error("ram window did not select first chip select");

  property p_periph_to_second;
    @(posedge clk) disable iff (!rst_n)
      (st_q == ST_DATA && dual_q && ram_q != REGION_NONE
       && periph_q != REGION_NONE && code_q == REGION_NONE
       && ((periph_q == REGION_LOW && addr_q[31:28] == PERIPH_WIN_LOW)
        || (periph_q == REGION_HIGH && addr_q[31:28] == PERIPH_WIN_HIGH)))
      |-> chip_select_second && !chip_select_first;
  endproperty
  a_periph_to_second: assert property (p_periph_to_second)
    else $error("peripheral window did not select second chip select");

  property p_no_swap_with_code;
    @(posedge clk) disable iff (!rst_n)
      (st_q == ST_DATA && dual_q && code_q != REGION_NONE
       && ram_q == REGION_LOW && periph_q == REGION_NONE
       && addr_q[31:28] == RAM_WIN_LOW) |-> chip_select_second;
  endproperty
  a_no_swap_with_code: assert property (p_no_swap_with_code)
    else $error("swap applied outside its configuration");

  property p_outside_deasserted;
    @(posedge clk) disable iff (!rst_n)
      (addr_q[31:28] != RAM_WIN_LOW && addr_q[31:28] != RAM_WIN_HIGH
       && addr_q[31:28] != PERIPH_WIN_LOW
       && addr_q[31:28] != PERIPH_WIN_HIGH)
      |-> !chip_select_first && !chip_select_second;
  endproperty
  a_outside_deasserted: assert property (p_outside_deasserted)
    else $error("chip select asserted outside all windows");

  property p_select_follows_strobe;
    @(posedge clk) disable iff (!rst_n)
      (chip_select_first || chip_select_second)
      |-> $past(address_latch_strobe) == $past(pol_q);
  endproperty
  a_select_follows_strobe: assert property (p_select_follows_strobe)
    else $error("chip select without preceding strobe");

  property p_reset_readback;
    @(posedge clk) $rose(rst_n) |-> latch_strobe_polarity_high;
  endproperty
  a_reset_readback: assert property (p_reset_readback)
    else $error("polarity readback not 1 after reset");

  property p_single_select;
    @(posedge clk) disable iff (!rst_n)
      !(chip_select_first && chip_select_second);
  endproperty
  a_single_select: assert property (p_single_select)
    else $error("both chip selects asserted together");

endmodule
`default_nettype wire

//--- logic/ext_bus_pkg.sv
package ext_bus_pkg;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int ADDR_W = 32;
  localparam int REGION_W = 2;

  // ==========================================================================
  // region field encodings
  // ==========================================================================
  localparam logic [1:0] REGION_NONE = 2'h0;
  localparam logic [1:0] REGION_LOW = 2'h1;
  localparam logic [1:0] REGION_HIGH = 2'h2;

  // ==========================================================================
  // address windows, 256 MB each, matched on the top nibble
  // ==========================================================================
  localparam int WIN_MSB = 31;
  localparam int WIN_LSB = 28;
  localparam logic [3:0] RAM_WIN_LOW = 4'h6;
  localparam logic [3:0] RAM_WIN_HIGH = 4'h8;
  localparam logic [3:0] PERIPH_WIN_LOW = 4'ha;
  localparam logic [3:0] PERIPH_WIN_HIGH = 4'hc;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic POLARITY_RESET = 1'b1;
  localparam logic [1:0] REGION_RESET = 2'h0;

  // ==========================================================================
  // access sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } access_state_e;

endpackage

//--- logic/region_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface region_cfg_if;
  import ext_bus_pkg::*;
  logic [REGION_W-1:0] ram_region_select;
  logic [REGION_W-1:0] peripheral_region_select;
  logic [REGION_W-1:0] code_region_select;
  logic dual_cs_mode;
  modport src (
    output ram_region_select, peripheral_region_select,
    output code_region_select, dual_cs_mode
  );
  modport dst (
    input ram_region_select, peripheral_region_select,
    input code_region_select, dual_cs_mode
  );
endinterface
`default_nettype wire

//--- verif/ext_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// external memory: latches address on strobe
// ==========================================
module ext_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe_active_level,
  input wire logic address_latch_strobe,
  input wire logic [31:0] bus_addr,
  output logic [31:0] latched_addr
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_addr <= 32'h0;
    end else if (address_latch_strobe == strobe_active_level) begin
      latched_addr <= bus_addr;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_ext_bus_chip_select_ale.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ext_bus_chip_select_ale;
  import ext_bus_pkg::*;
  // ==========================================
  // signals
  // ==========================================
  logic clk, rst_n, cfg_write, pol_in, dual_in, req_valid, req_ready;
  logic pol_rb, ale, cs0, cs1, model_pol;
  logic [1:0] ram_in, per_in, code_in;
  logic [31:0] req_addr, bus_addr, m_addr;
  int bad_count, checks_done, seed, c_pol, c_ram, c_per, c_code, c_dual;
  logic [3:0] nibs [0:4];
  ext_bus_chip_select_ale ext_bus_chip_select_ale_i (.clk(clk),
    .rst_n(rst_n), .cfg_write(cfg_write),
    .latch_strobe_polarity_high_in(pol_in), .ram_region_in(ram_in),
    .peripheral_region_in(per_in), .code_region_in(code_in),
    .dual_cs_mode_in(dual_in), .req_valid(req_valid),
    .req_addr(req_addr), .req_ready(req_ready),
    .latch_strobe_polarity_high(pol_rb), .address_latch_strobe(ale),
    .chip_select_first(cs0), .chip_select_second(cs1),
    .bus_addr(bus_addr));
  ext_mem_model ext_mem_model_i (.clk(clk), .rst_n(rst_n),
    .strobe_active_level(model_pol), .address_latch_strobe(ale),
    .bus_addr(bus_addr), .latched_addr(m_addr));
  always #2 clk = ~clk;
  // ==========================================
  // tasks
  // ==========================================
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic int win(int r, int lo, int hi, int n);
    return (r == 1) ? (n == lo) : ((r == 2) ? (n == hi) : 0);
  endfunction
  task automatic cfg(input int p, input int r, input int q, input int c,
                     input int d);
    @(posedge clk);
    cfg_write <= 1'b1;
    pol_in <= p[0];
    ram_in <= r[1:0];
    per_in <= q[1:0];
    code_in <= c[1:0];
    dual_in <= d[0];
    @(posedge clk);
    cfg_write <= 1'b0;
    c_pol = p;
    c_ram = r;
    c_per = q;
    c_code = c;
    c_dual = d;
    model_pol <= p[0];
    @(posedge clk);
    @(negedge clk);
    check(pol_rb, p[0]);
    check(ale, !p[0]);
  endtask
  task automatic access(input logic [31:0] a);
    int n, rh, ph, f, s, k;
    n = a[31:28];
    rh = win(c_ram, 6, 8, n);
    ph = win(c_per, 10, 12, n);
    if (c_dual == 0) begin
      f = rh | ph;
      s = 0;
    end else if (c_ram != 0 && c_per != 0 && c_code == 0) begin
      f = rh;
      s = ph;
    end else begin
      f = ph;
      s = rh;
    end
    k = 0;
    while (req_ready !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20) begin
      bad_count++;
      summarize();
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    @(negedge clk);
    check(ale, c_pol[0]);
    check(bus_addr, a);
    check(req_ready, 1'b0);
    @(negedge clk);
    check(ale, !c_pol[0]);
    check(cs0, f[0]);
    check(cs1, s[0]);
    check(m_addr, a);
    @(negedge clk);
    check({cs1, cs0, req_ready}, 3'h1);
  endtask
  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    int r, i, j;
    clk = 0;
    rst_n = 0;
    cfg_write = 0;
    pol_in = 1;
    dual_in = 0;
    req_valid = 0;
    ram_in = 0;
    per_in = 0;
    code_in = 0;
    req_addr = 0;
    model_pol = 1;
    bad_count = 0;
    checks_done = 0;
    seed = 32'hc7cf;
    nibs = '{4'h6, 4'h8, 4'ha, 4'hc, 4'h0};
    c_pol = 1;
    c_ram = 0;
    c_per = 0;
    c_code = 0;
    c_dual = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(pol_rb, 1'b1);
    check(ale, 1'b0);
    access(32'h6000_0010);
    $display("test reset done");
    cfg(1, 1, 1, 0, 1);
    access(32'h6123_4560);
    access(32'ha000_0004);
    access(32'h8000_0000);
    access(32'hc000_0000);
    cfg(0, 2, 2, 0, 1);
    access(32'h8fff_fffc);
    access(32'hcfff_fffc);
    access(32'h6000_0000);
    @(posedge clk);
    rst_n <= 1'b0;
    model_pol <= 1'b1;
    c_pol = 1;
    c_ram = 0;
    c_per = 0;
    c_code = 0;
    c_dual = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check(pol_rb, 1'b1);
    check(ale, 1'b0);
    access(32'h8fff_fffc);
    $display("test mid-run reset done");
    cfg(1, 1, 2, 1, 1);
    access(32'h6000_0000);
    access(32'hc000_0000);
    cfg(0, 1, 0, 3, 1);
    access(32'h6000_0000);
    cfg(1, 2, 0, 0, 1);
    access(32'h8000_0000);
    $display("test directed done");
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      cfg(r[0], r[2:1], r[4:3], r[6:5] & {2{r[7]}}, r[8]);
      for (j = 0; j < 4; j++) begin
        r = $random(seed);
        nibs[4] = r[3:0];
        access({nibs[r[6:4] % 5], r[31:8], 4'h0});
      end
    end
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
